// ---- ipfm_pkg.sv ----
// Constants shared by the interrupt pin function mux files
package ipfm_pkg;
  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIMER = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam int ADR_W = 8;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int CTRL_FN_LSB = 0;
  localparam int CTRL_SENSE_LSB = 3;
  localparam int CTRL_CORE_EDGE = 5;
  localparam int CTRL_GP_OE = 6;
  localparam int CTRL_GP_OUT = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Timer register fields
  localparam int TMR_FN_LSB = 0;
  localparam int TMR_OE_LSB = 8;
  localparam int TMR_OUT_LSB = 16;
  localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
  localparam int TMR_N = 8;

  // Status register fields
  localparam int ST_PAD = 0;
  localparam int ST_EXT = 1;
  localparam int ST_DTR = 2;
  localparam int ST_CORE = 3;
  localparam int ST_SEL = 4;
  localparam int ST_TPAD_LSB = 8;

  // ************************************************************
  // Pad functions and sense modes
  // ************************************************************
  localparam logic [2:0] FN_GPIO = 3'h0;
  localparam logic [2:0] FN_IRQ = 3'h1;
  localparam logic [2:0] FN_CODEC = 3'h2;
  localparam logic [2:0] FN_DTR = 3'h3;
  localparam logic [2:0] FN_SCLK = 3'h4;
  localparam logic [2:0] FN_JTAG = 3'h7;
  localparam logic [1:0] SENSE_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;

  // ************************************************************
  // Pin synchroniser lanes
  // ************************************************************
  localparam int PIN_N = 5;
  localparam int PIN_TMS = 0;
  localparam int PIN_PAD = 1;
  localparam int PIN_CORE = 2;
  localparam int PIN_SEL = 3;
  localparam int PIN_CODEC = 4;
  // Pulled-up pins idle high, the select idles low
  localparam logic [4:0] PIN_INIT = 5'h17;
  localparam logic [7:0] TPAD_INIT = 8'h00;
endpackage

// ---- ipfm_sync_if.sv ----
// Interface between a pin synchroniser and its user
`timescale 1ns/100ps
interface ipfm_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (input raw, output level, output rise, output fall);
  modport dst (output raw, input level, input rise, input fall);
endinterface

// ---- ipfm_sync.sv ----
// Two-stage pin synchroniser with edge detection
`timescale 1ns/100ps
module ipfm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Synchronised pins
  ipfm_sync_if.src s
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= INIT;
      stable <= INIT;
      prev <= INIT;
    end else begin
      meta <= s.raw;
      stable <= meta;
      prev <= stable;
    end
  end

  assign s.level = stable;
  assign s.rise = stable & ~prev;
  assign s.fall = ~stable & prev;

  a_sync_two_ff: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(rst_i, 2)) |-> (stable == $past(s.raw, 2)))
    else $error("synchroniser is not two stages deep");
endmodule

// ---- ipfm_top.sv ----
// Pin function mux: interrupt pad, core request, JTAG select, timer pads
// Functional notes
// - Select low: pad serves interrupt logic or GPIO, as software picks.
// - Pad interrupt senses active level, rising edge or falling edge.
// - Codec function feeds pad into codec receive path, primary pin off.
// - Terminal-ready function raises serial port interrupt on both edges.
// - Serial clock function passes pad as UART input clock.
// - After reset pad is GPIO input; GPIO whenever no other function.
// - Select high: pad drives TAP mode select, dedicated pin cut off.
// - TAP samples mode select on rising TCK; host keeps it valid there.
// - Active-low core request is level or falling-edge sensitive, maskable; here no mask bit exists, core_irq_req_o is never masked.
// - Core request while core stopped wakes the core.
// - Pull resistors disconnected whenever the pad is an output.
// - Eight timer pads carry timer outputs, else GPIO, input after reset.
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module ipfm_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Global pin function select pin
  input wire logic pin_function_select_i,
  // Multi-function interrupt pad seven
  input wire logic external_irq_line_seven_i,
  output logic external_irq_line_seven_o,
  output logic external_irq_line_seven_oe_o,
  output logic external_irq_line_seven_pull_en_o,
  // JTAG mode select
  input wire logic tms_pin_i,
  output logic tap_tms_o,
  // Codec receive data
  input wire logic codec_rx_data_primary_i,
  output logic codec_rx_data_o,
  output logic codec_rx_primary_en_o,
  // Serial data port
  output logic uart_clk_o,
  output logic sdp_irq_o,
  // External interrupt to the interrupt logic
  output logic ext_irq_o,
  // Signal core request and stop state
  input wire logic signal_core_irq_n_i,
  input wire logic core_stop_i,
  output logic core_irq_req_o,
  output logic core_wake_o,
  // Timer pads
  input wire logic [7:0] timer_i,
  input wire logic [7:0] timer_output_lines_i,
  output logic [7:0] timer_output_lines_o,
  output logic [7:0] timer_output_lines_oe_o
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  ipfm_sync_if #(.W(ipfm_pkg::PIN_N)) pins ();
  ipfm_sync_if #(.W(ipfm_pkg::TMR_N)) tpads ();

  assign pins.raw = {codec_rx_data_primary_i, pin_function_select_i, signal_core_irq_n_i,
                     external_irq_line_seven_i, tms_pin_i};
  assign tpads.raw = timer_output_lines_i;

  ipfm_sync #(.W(ipfm_pkg::PIN_N), .INIT(ipfm_pkg::PIN_INIT)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s(pins)
  );

  ipfm_sync #(.W(ipfm_pkg::TMR_N), .INIT(ipfm_pkg::TPAD_INIT)) u_tpad_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s(tpads)
  );

  logic sel_hi;
  logic pad_lvl;
  logic pad_rise;
  logic pad_fall;
  logic core_lvl;
  logic core_fall;
  assign sel_hi = pins.level[ipfm_pkg::PIN_SEL];
  assign pad_lvl = pins.level[ipfm_pkg::PIN_PAD];
  assign pad_rise = pins.rise[ipfm_pkg::PIN_PAD];
  assign pad_fall = pins.fall[ipfm_pkg::PIN_PAD];
  assign core_lvl = pins.level[ipfm_pkg::PIN_CORE];
  assign core_fall = pins.fall[ipfm_pkg::PIN_CORE];

  // ************************************************************
  // Register file
  // ************************************************************
  logic [31:0] ctrl;
  logic [31:0] tmr;
  logic ext_pend;
  logic dtr_pend;
  logic core_pend;
  logic req;
  logic wr;
  logic hit_ctrl;
  logic hit_tmr;
  logic hit_status;

  assign req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples ack
  assign wr = req & wb_we_i & wb_ack_o;
  assign hit_ctrl = {wb_adr_i[7:2], 2'h0} == ipfm_pkg::OFF_CTRL;
  assign hit_tmr = {wb_adr_i[7:2], 2'h0} == ipfm_pkg::OFF_TIMER;
  assign hit_status = {wb_adr_i[7:2], 2'h0} == ipfm_pkg::OFF_STATUS;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= ipfm_pkg::CTRL_RESET;
      tmr <= ipfm_pkg::TIMER_RESET;
    end else if (wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && hit_ctrl) begin
          ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
        if (wb_sel_i[b] && hit_tmr) begin
          tmr[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  logic [2:0] fn_raw;
  logic [1:0] sense;
  logic core_edge;
  logic [2:0] eff_fn;
  assign fn_raw = ctrl[ipfm_pkg::CTRL_FN_LSB +: 3];
  assign sense = ctrl[ipfm_pkg::CTRL_SENSE_LSB +: 2];
  assign core_edge = ctrl[ipfm_pkg::CTRL_CORE_EDGE];

  // Global select beats the field; unknown codes fall back to GPIO
  always_comb begin
    if (sel_hi) begin
      eff_fn = ipfm_pkg::FN_JTAG;
    end else if (fn_raw > ipfm_pkg::FN_SCLK) begin
      eff_fn = ipfm_pkg::FN_GPIO;
    end else begin
      eff_fn = fn_raw;
    end
  end

  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[ipfm_pkg::ST_PAD] = pad_lvl;
    status[ipfm_pkg::ST_EXT] = ext_pend;
    status[ipfm_pkg::ST_DTR] = dtr_pend;
    status[ipfm_pkg::ST_CORE] = core_pend;
    status[ipfm_pkg::ST_SEL] = sel_hi;
    status[ipfm_pkg::ST_TPAD_LSB +: 8] = tpads.level;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_ack_o) begin
      if (hit_ctrl) begin
        wb_dat_o <= ctrl;
      end else if (hit_tmr) begin
        wb_dat_o <= tmr;
      end else if (hit_status) begin
        wb_dat_o <= status;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ************************************************************
  // Sticky pending flags, write one to clear, set wins
  // ************************************************************
  logic clr_ok;
  logic ext_set;
  logic dtr_set;
  logic core_set;
  assign clr_ok = wr & hit_status & wb_sel_i[0];
  assign ext_set = (eff_fn == ipfm_pkg::FN_IRQ) &&
                   (((sense == ipfm_pkg::SENSE_RISE) && pad_rise) ||
                    ((sense == ipfm_pkg::SENSE_FALL) && pad_fall));
  assign dtr_set = (eff_fn == ipfm_pkg::FN_DTR) && (pad_rise || pad_fall);
  assign core_set = core_edge && core_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_pend <= 1'b0;
      dtr_pend <= 1'b0;
      core_pend <= 1'b0;
    end else begin
      ext_pend <= (ext_pend & ~(clr_ok & wb_dat_i[ipfm_pkg::ST_EXT])) | ext_set;
      dtr_pend <= (dtr_pend & ~(clr_ok & wb_dat_i[ipfm_pkg::ST_DTR])) | dtr_set;
      core_pend <= (core_pend & ~(clr_ok & wb_dat_i[ipfm_pkg::ST_CORE])) | core_set;
    end
  end

  // ************************************************************
  // Pad seven drive and function routing
  // ************************************************************
  logic next_oe;
  assign next_oe = (eff_fn == ipfm_pkg::FN_GPIO) && ctrl[ipfm_pkg::CTRL_GP_OE];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_irq_line_seven_o <= 1'b0;
      external_irq_line_seven_oe_o <= 1'b0;
      external_irq_line_seven_pull_en_o <= 1'b1;
    end else begin
      external_irq_line_seven_o <= ctrl[ipfm_pkg::CTRL_GP_OUT];
      external_irq_line_seven_oe_o <= next_oe;
      external_irq_line_seven_pull_en_o <= ~next_oe;
    end
  end

  // Registering adds 100 to 150 ns of lag, so TCK must stay well below 20 MHz
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_tms_o <= 1'b1;
    end else if (sel_hi) begin
      tap_tms_o <= pad_lvl;
    end else begin
      tap_tms_o <= pins.level[ipfm_pkg::PIN_TMS];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      codec_rx_data_o <= 1'b0;
      codec_rx_primary_en_o <= 1'b1;
      uart_clk_o <= 1'b0;
    end else begin
      codec_rx_primary_en_o <= eff_fn != ipfm_pkg::FN_CODEC;
      codec_rx_data_o <= (eff_fn == ipfm_pkg::FN_CODEC) ? pad_lvl :
                         pins.level[ipfm_pkg::PIN_CODEC];
      uart_clk_o <= (eff_fn == ipfm_pkg::FN_SCLK) && pad_lvl;
    end
  end

  // ************************************************************
  // Interrupt outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq_o <= 1'b0;
      sdp_irq_o <= 1'b0;
      core_irq_req_o <= 1'b0;
      core_wake_o <= 1'b0;
    end else begin
      // Level mode treats a low pad as active, matching its pull-up
      if (eff_fn != ipfm_pkg::FN_IRQ) begin
        ext_irq_o <= 1'b0;
      end else if (sense == ipfm_pkg::SENSE_RISE || sense == ipfm_pkg::SENSE_FALL) begin
        ext_irq_o <= ext_pend | ext_set;
      end else begin
        ext_irq_o <= ~pad_lvl;
      end
      sdp_irq_o <= dtr_pend | dtr_set;
      core_irq_req_o <= core_edge ? (core_pend | core_set) : ~core_lvl;
      core_wake_o <= core_stop_i & ~core_lvl;
    end
  end

  // ************************************************************
  // Timer pads
  // ************************************************************
  logic [7:0] tfn;
  assign tfn = tmr[ipfm_pkg::TMR_FN_LSB +: 8];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_output_lines_o <= 8'h00;
      timer_output_lines_oe_o <= 8'h00;
    end else begin
      timer_output_lines_o <= (tfn & timer_i) | (~tfn & tmr[ipfm_pkg::TMR_OUT_LSB +: 8]);
      timer_output_lines_oe_o <= tfn | tmr[ipfm_pkg::TMR_OE_LSB +: 8];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_core_edge_fall;
    core_edge ##0 core_fall;
  endsequence

  sequence s_dtr_toggle;
    (eff_fn == ipfm_pkg::FN_DTR) ##0 (pad_rise || pad_fall);
  endsequence

  a_gpio_pad_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (eff_fn == ipfm_pkg::FN_GPIO && ctrl[ipfm_pkg::CTRL_GP_OE]) |=>
    (external_irq_line_seven_oe_o && external_irq_line_seven_o == $past(ctrl[ipfm_pkg::CTRL_GP_OUT])))
    else $error("GPIO drive of pad seven lost");

  a_ext_level_sense: assert property (@(posedge clk_i) disable iff (rst_i)
    (eff_fn == ipfm_pkg::FN_IRQ && sense == ipfm_pkg::SENSE_LEVEL) |=> (ext_irq_o == !$past(pad_lvl)))
    else $error("level interrupt does not follow pad");

  a_codec_alt_path: assert property (@(posedge clk_i) disable iff (rst_i)
    (eff_fn == ipfm_pkg::FN_CODEC) |=> (!codec_rx_primary_en_o && codec_rx_data_o == $past(pad_lvl)))
    else $error("codec alternate receive path wrong");

  a_dtr_both_edges: assert property (@(posedge clk_i) disable iff (rst_i)
    s_dtr_toggle |=> sdp_irq_o [*2])
    else $error("terminal-ready edge gave no serial port interrupt");

  a_uart_clk_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (eff_fn != ipfm_pkg::FN_SCLK) |=> !uart_clk_o)
    else $error("UART clock leaks from pad");

  a_reset_pad_input: assert property (@(posedge clk_i)
    rst_i |=> (!external_irq_line_seven_oe_o && timer_output_lines_oe_o == 8'h00))
    else $error("pads not inputs after reset");

  a_jtag_tms_route: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_hi |=> (tap_tms_o == $past(pad_lvl) && !external_irq_line_seven_oe_o))
    else $error("mode select not taken from pad seven");

  a_core_edge_req: assert property (@(posedge clk_i) disable iff (rst_i)
    s_core_edge_fall |=> core_irq_req_o)
    else $error("core falling edge request missed");

  a_core_stop_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    (core_stop_i && !core_lvl) |=> core_wake_o)
    else $error("stopped core not woken");

  a_pull_off_out: assert property (@(posedge clk_i) disable iff (rst_i)
    external_irq_line_seven_oe_o |-> !external_irq_line_seven_pull_en_o)
    else $error("pull resistor on while pad drives");

  a_timer_route: assert property (@(posedge clk_i) disable iff (rst_i)
    tfn[0] |=> (timer_output_lines_oe_o[0] && timer_output_lines_o[0] == $past(timer_i[0])))
    else $error("timer output not on pad");
endmodule

// ---- ipfm_pin_model.sv ----
// Model of the outside sources: pads, global select, core request, timer pads
`timescale 1ns/100ps
module ipfm_pin_model (
  // Clock
  input wire logic clk_i,
  // Levels driven onto the pads
  output logic [4:0] pins_o,
  output logic [7:0] tpad_o
);
  // ************************************************************
  // Pad drivers
  // ************************************************************
  initial begin
    pins_o = ipfm_pkg::PIN_INIT;
    tpad_o = ipfm_pkg::TPAD_INIT;
  end

  // Levels move only just after a rising edge, so mode select is steady at each sample
  task automatic put(input int lane, input logic v);
    @(posedge clk_i);
    pins_o[lane] <= v;
  endtask

  task automatic put_timer(input logic [7:0] v);
    @(posedge clk_i);
    tpad_o <= v;
  endtask
endmodule

// ---- ipfm_test.sv ----
// Self-checking bench for the interrupt pin function mux
`timescale 1ns/100ps
module ipfm_test;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, pad_o, pad_oe, pull_en, tap_tms, codec_data, codec_en;
  logic uart_clk, sdp_irq, ext_irq, core_req, core_wake, pad_w;
  logic core_stop_i = 1'b0;
  logic [7:0] timer_i = 8'h00, tl_o, tl_oe, tl_w, tpad;
  logic [4:0] pins;
  int checked = 0, err_total = 0;

  // Pad levels: the design wins while it drives, else the outside source shows
  assign pad_w = pad_oe ? pad_o : pins[ipfm_pkg::PIN_PAD];
  assign tl_w = (tl_oe & tl_o) | (~tl_oe & tpad);

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  ipfm_pin_model ipfm_pin_model_inst (.clk_i(clk_i), .pins_o(pins), .tpad_o(tpad));

  ipfm_top ipfm_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_function_select_i(pins[ipfm_pkg::PIN_SEL]), .external_irq_line_seven_i(pad_w),
    .external_irq_line_seven_o(pad_o), .external_irq_line_seven_oe_o(pad_oe),
    .external_irq_line_seven_pull_en_o(pull_en), .tms_pin_i(pins[ipfm_pkg::PIN_TMS]), .tap_tms_o(tap_tms),
    .codec_rx_data_primary_i(pins[ipfm_pkg::PIN_CODEC]), .codec_rx_data_o(codec_data),
    .codec_rx_primary_en_o(codec_en), .uart_clk_o(uart_clk), .sdp_irq_o(sdp_irq), .ext_irq_o(ext_irq),
    .signal_core_irq_n_i(pins[ipfm_pkg::PIN_CORE]), .core_stop_i(core_stop_i), .core_irq_req_o(core_req),
    .core_wake_o(core_wake), .timer_i(timer_i), .timer_output_lines_i(tl_w), .timer_output_lines_o(tl_o),
    .timer_output_lines_oe_o(tl_oe)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic done(input string name);
    $display("test %s done, %0d checks, %0d mismatches", name, checked, err_total);
  endtask

  // Outputs lag a pin change by 3 cycles; sample clear of the edge
  task automatic settle();
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n == 20) begin
      err_total++;
      $display("BAD wb_ack expected 1 seen 0");
      print_verdict();
    end
  endtask

  task automatic wb_wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] rd;
    wb_xfer(1'b1, adr, wd, rd);
  endtask

  task automatic wb_rd(input logic [7:0] adr, output logic [31:0] rd);
    wb_xfer(1'b0, adr, 32'h0, rd);
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    logic [31:0] rd;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    check("pad_oe", 0, pad_oe);
    check("pull_en", 1, pull_en);
    check("tap_tms", 1, tap_tms);
    check("codec_en", 1, codec_en);
    check("timer_oe", 0, tl_oe);
    wb_rd(ipfm_pkg::OFF_CTRL, rd);
    check("ctrl", 32'h0, rd);
    wb_rd(8'h0c, rd);
    check("unmapped", 32'h0, rd);
    done("reset");

    wb_wr(ipfm_pkg::OFF_CTRL, 32'h0000_00c0);
    settle();
    check("pad_oe", 1, pad_oe);
    check("pull_en", 0, pull_en);
    check("pad_o", 1, pad_o);
    wb_wr(ipfm_pkg::OFF_CTRL, 32'h0000_0040);
    settle();
    wb_rd(ipfm_pkg::OFF_STATUS, rd);
    check("pad_level", 0, rd[0]);
    wb_rd(ipfm_pkg::OFF_CTRL, rd);
    check("ctrl", 32'h0000_0040, rd);
    done("gpio");

    for (int s = 0; s < 4; s++) begin
      wb_wr(ipfm_pkg::OFF_CTRL, {27'h0, 2'(s), 3'h1});
      ipfm_pin_model_inst.put(ipfm_pkg::PIN_PAD, s != 1);
      settle();
      wb_wr(ipfm_pkg::OFF_STATUS, 32'h2);
      settle();
      check("ext_irq", 0, ext_irq);
      ipfm_pin_model_inst.put(ipfm_pkg::PIN_PAD, s == 1);
      settle();
      check("ext_irq", 1, ext_irq);
      ipfm_pin_model_inst.put(ipfm_pkg::PIN_PAD, s != 1);
      settle();
      check("ext_irq", s == 1 || s == 2, ext_irq);
      wb_wr(ipfm_pkg::OFF_STATUS, 32'h2);
      settle();
      check("ext_irq", 0, ext_irq);
    end
    done("sense");

    wb_wr(ipfm_pkg::OFF_CTRL, 32'h2);
    for (int v = 0; v < 2; v++) begin
      ipfm_pin_model_inst.put(ipfm_pkg::PIN_CODEC, !v[0]);
      ipfm_pin_model_inst.put(ipfm_pkg::PIN_PAD, v[0]);
      settle();
      check("codec_data", v, codec_data);
    end
    check("codec_en", 0, codec_en);
    done("codec");

    wb_wr(ipfm_pkg::OFF_CTRL, 32'h3);
    settle();
    wb_wr(ipfm_pkg::OFF_STATUS, 32'h4);
    settle();
    check("sdp_irq", 0, sdp_irq);
    for (int v = 0; v < 2; v++) begin
      ipfm_pin_model_inst.put(ipfm_pkg::PIN_PAD, v[0]);
      settle();
      check("sdp_irq", 1, sdp_irq);
      wb_wr(ipfm_pkg::OFF_STATUS, 32'h4);
      settle();
      check("sdp_irq", 0, sdp_irq);
    end
    done("dtr");

    wb_wr(ipfm_pkg::OFF_CTRL, 32'h4);
    for (int v = 0; v < 2; v++) begin
      ipfm_pin_model_inst.put(ipfm_pkg::PIN_PAD, v[0]);
      settle();
      check("uart_clk", v, uart_clk);
    end
    wb_wr(ipfm_pkg::OFF_CTRL, 32'h5);
    settle();
    check("uart_clk", 0, uart_clk);
    check("codec_en", 1, codec_en);
    done("sclk");

    wb_wr(ipfm_pkg::OFF_CTRL, 32'h0000_00c1);
    ipfm_pin_model_inst.put(ipfm_pkg::PIN_SEL, 1'b1);
    for (int v = 0; v < 2; v++) begin
      ipfm_pin_model_inst.put(ipfm_pkg::PIN_PAD, v[0]);
      ipfm_pin_model_inst.put(ipfm_pkg::PIN_TMS, !v[0]);
      settle();
      check("tap_tms", v, tap_tms);
      check("pad_oe", 0, pad_oe);
      check("ext_irq", 0, ext_irq);
    end
    // GPIO drive requested while the select is high must stay off the pad
    wb_wr(ipfm_pkg::OFF_CTRL, 32'h0000_00c0);
    settle();
    check("pad_oe", 0, pad_oe);
    ipfm_pin_model_inst.put(ipfm_pkg::PIN_SEL, 1'b0);
    ipfm_pin_model_inst.put(ipfm_pkg::PIN_TMS, 1'b0);
    settle();
    check("tap_tms", 0, tap_tms);
    done("jtag");

    wb_wr(ipfm_pkg::OFF_CTRL, 32'h0);
    ipfm_pin_model_inst.put(ipfm_pkg::PIN_CORE, 1'b0);
    core_stop_i <= 1'b1;
    settle();
    check("core_req", 1, core_req);
    check("core_wake", 1, core_wake);
    ipfm_pin_model_inst.put(ipfm_pkg::PIN_CORE, 1'b1);
    core_stop_i <= 1'b0;
    settle();
    check("core_req", 0, core_req);
    check("core_wake", 0, core_wake);
    wb_wr(ipfm_pkg::OFF_CTRL, 32'h20);
    wb_wr(ipfm_pkg::OFF_STATUS, 32'h8);
    ipfm_pin_model_inst.put(ipfm_pkg::PIN_CORE, 1'b0);
    settle();
    check("core_wake", 0, core_wake);
    ipfm_pin_model_inst.put(ipfm_pkg::PIN_CORE, 1'b1);
    settle();
    check("core_req", 1, core_req);
    wb_wr(ipfm_pkg::OFF_STATUS, 32'h8);
    settle();
    check("core_req", 0, core_req);
    done("core");

    wb_wr(ipfm_pkg::OFF_TIMER, 32'h00ff_300f);
    timer_i <= 8'ha5;
    settle();
    check("timer_oe", 8'h3f, tl_oe);
    check("timer_out", 8'h35, tl_o & tl_oe);
    wb_rd(ipfm_pkg::OFF_STATUS, rd);
    check("timer_pads", 8'h35, rd[15:8]);
    wb_rd(ipfm_pkg::OFF_TIMER, rd);
    check("timer_reg", 32'h00ff_300f, rd);
    // Undriven pads show what the outside puts on them
    ipfm_pin_model_inst.put_timer(8'hc0);
    settle();
    wb_rd(ipfm_pkg::OFF_STATUS, rd);
    check("timer_pads", 8'hf5, rd[15:8]);
    done("timer");
    print_verdict();
  end
endmodule
